/* File: core/ifeb_pkg.sv */
package ifeb_pkg;

    // ****************************************************************
    // Register map (byte addresses on the 32-bit register bus)
    // ****************************************************************
    localparam logic [7:0] OFS_GROUP_CTRL = 8'h00; // Group pending and group enables
    localparam logic [7:0] OFS_TBPIN = 8'h04; // timebase_extpin_irq_ctrl
    localparam logic [7:0] OFS_SERUART = 8'h08; // serial_uart_irq_ctrl
    localparam logic [7:0] OFS_PTIMER = 8'h0c; // periodic_timer_group_irq
    localparam logic [7:0] OFS_VOLTSTM = 8'h10; // voltage_eeprom_stdtimer_group_irq
    localparam logic [7:0] OFS_ATIMER = 8'h14; // audio_timer_group_irq
    localparam logic [7:0] OFS_PIN23 = 8'h18; // extpin_pair_group_irq
    localparam logic [7:0] OFS_GLOBAL = 8'h1c; // global_irq_enable

    // ****************************************************************
    // Register indices inside the bank
    // ****************************************************************
    localparam int unsigned NUM_REGS = 8;
    localparam logic [2:0] IDX_GROUP_CTRL = 3'h0;
    localparam logic [2:0] IDX_TBPIN = 3'h1;
    localparam logic [2:0] IDX_SERUART = 3'h2;
    localparam logic [2:0] IDX_PTIMER = 3'h3;
    localparam logic [2:0] IDX_VOLTSTM = 3'h4;
    localparam logic [2:0] IDX_ATIMER = 3'h5;
    localparam logic [2:0] IDX_PIN23 = 3'h6;
    localparam logic [2:0] IDX_GLOBAL = 3'h7;
    localparam int unsigned NUM_GROUPS = 4;

    // ****************************************************************
    // Field layout: flags in the high nibble, enables in the low nibble
    // ****************************************************************
    localparam int unsigned FLAG_LSB = 4;
    localparam int unsigned ENA_LSB = 0;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned GLOBAL_BIT = 0;
    localparam int unsigned PIN4_FLAG_BIT = 6;
    localparam int unsigned PIN5_FLAG_BIT = 7;

    // Implemented bits per register; the rest read as zero
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_SERUART = 8'h77;
    localparam logic [7:0] MASK_ATIMER = 8'h77;
    localparam logic [7:0] MASK_PIN23 = 8'h33;
    localparam logic [7:0] MASK_GLOBAL = 8'h01;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ****************************************************************
    // Service request numbering (index into the active request vector)
    // ****************************************************************
    localparam int unsigned NUM_REQ = 12;
    localparam logic [3:0] SVC_GROUP_LAST = 4'h3; // 0..3 are groups 0..3
    localparam logic [3:0] SVC_PIN4 = 4'h6;
    localparam logic [3:0] SVC_PIN5 = 4'h7;

    // ****************************************************************
    // Bus answers
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: core/ifeb_flag_bank.sv */
// Summary of operation
// - Group 1 and 0 enables at bits 1,0
// - Bank two: pin5 flag bit7, pin4 bit6
// - Bank two: timebase1 flag bit5, timebase0 bit4
// - Bank three flags: serial 6, uart1 5, uart0 4
// - Unimplemented bits always read zero
// - Flag reads one from its event until cleared, enabled or not
// - Enables gate sources; all bits RW, reset zero
// - Periodic group flags bits 7-4
// - Group source flags cleared only by software
// - Voltage/eeprom/stdtimer group flags bits 7-4
// - Voltage/eeprom/stdtimer group enables bits 3-0
// - Audio timer flags bits 6-4
// - Audio timer enables bits 2-0
// - Pin3 flag bit5, pin2 flag bit4
// - Pin3 enable bit1, pin2 enable bit0
// - Group pending sets when an enabled source flag sets
// - Disabled flag raises no request, stays recorded
// - Global enable low blocks every request
// - Pin4 and pin5 flags clear on service
`timescale 1ns/1ps
`default_nettype none

module ifeb_flag_bank
    import ifeb_pkg::*;
#(
    parameter int unsigned ADDR_W = 8 // Register bus address width
)
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Event pulses: bit0 tb0, bit1 tb1, bit2 pin4, bit3 pin5
    input wire logic [3:0] ev_timebase_pin,
    // Event pulses: bit0 uart0, bit1 uart1, bit2 serial interface
    input wire logic [2:0] ev_serial_uart,
    // Event pulses: bit0 t0 cmp P, bit1 t0 cmp A, bit2 t1 cmp P, bit3 t1 cmp A
    input wire logic [3:0] ev_ptimer,
    // Event pulses: bit0 stm cmp P, bit1 stm cmp A, bit2 eeprom, bit3 low volt
    input wire logic [3:0] ev_volt_stm,
    // Event pulses: bit0 cmp P, bit1 cmp A, bit2 cmp B
    input wire logic [2:0] ev_atimer,
    // Event pulses: bit0 pin2, bit1 pin3
    input wire logic [1:0] ev_pin23,
    // Core acknowledges service of one request
    input wire logic svc_ack,
    input wire logic [3:0] svc_index,
    // Requests to the core
    output logic [NUM_REQ-1:0] irq_active,
    output logic irq_request
);
    import ifeb_pkg::*;
    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Address decode, shared by the read and write paths
    function automatic logic [3:0] decode_addr(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = 8'(addr);
        unique case (a)
            OFS_GROUP_CTRL: decode_addr = {1'b1, IDX_GROUP_CTRL};
            OFS_TBPIN: decode_addr = {1'b1, IDX_TBPIN};
            OFS_SERUART: decode_addr = {1'b1, IDX_SERUART};
            OFS_PTIMER: decode_addr = {1'b1, IDX_PTIMER};
            OFS_VOLTSTM: decode_addr = {1'b1, IDX_VOLTSTM};
            OFS_ATIMER: decode_addr = {1'b1, IDX_ATIMER};
            OFS_PIN23: decode_addr = {1'b1, IDX_PIN23};
            OFS_GLOBAL: decode_addr = {1'b1, IDX_GLOBAL};
            default: decode_addr = 4'h0;
        endcase
    endfunction

    // Next value of one register: write, then service clear, then set
    function automatic logic [7:0] next_value(
        input logic [7:0] cur,
        input logic wr,
        input logic [7:0] wval,
        input logic [7:0] mask,
        input logic [7:0] clr,
        input logic [7:0] set
    );
        logic [7:0] v;
        v = wr ? wval : cur;
        v = v & ~clr;
        // Set applied last so a same-cycle event is never lost
        v = v | set;
        next_value = v & mask;
    endfunction

    // ****************************************************************
    // Bus handshake state
    // ****************************************************************
    logic aw_full_q; // Write address held
    logic w_full_q; // Write data held
    logic [ADDR_W-1:0] aw_addr_q; // Held write address
    logic [7:0] w_data_q; // Held low byte of write data
    logic w_lane_q; // Byte lane 0 strobe of held data
    logic bvalid_q; // Write answer pending
    logic [1:0] bresp_q; // Write answer code
    logic rvalid_q; // Read answer pending
    logic [1:0] rresp_q; // Read answer code
    logic [31:0] rdata_q; // Read data
    logic wr_go; // Both halves of a write present
    logic [3:0] wr_dec; // Decoded write target
    logic [3:0] rd_dec; // Decoded read target

    // Register bank
    logic [7:0] regs_q [NUM_REGS]; // Stored bytes
    logic [7:0] regs_d [NUM_REGS]; // Next bytes
    logic [7:0] mask_v [NUM_REGS]; // Implemented bits
    logic [7:0] set_v [NUM_REGS]; // Hardware set terms
    logic [7:0] clr_v [NUM_REGS]; // Service clear terms
    logic [NUM_GROUPS-1:0] grp_set; // Group pending set terms
    logic global_en; // Global enable bit

    // Address takes and data takes are independent; a new one waits for the answer
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign wr_go = aw_full_q && w_full_q && !bvalid_q;
    assign wr_dec = decode_addr(aw_addr_q);
    assign rd_dec = decode_addr(s_axi_araddr);

    // ****************************************************************
    // Write channel capture
    // ****************************************************************
    // Hold the write address until the write is done
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (wr_go)
        begin
            aw_full_q <= 1'b0;
        end
    end

    // Hold the write data; only the low byte carries register bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
        end
        else if (wr_go)
        begin
            w_full_q <= 1'b0;
        end
    end

    // Write answer: unmapped address gets an error, no register changes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_dec[3] ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    // Reads have no side effect; flags are cleared by writing zero, and group pending and pin4/pin5 also by service
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            // Unmapped reads return zero with an error
            rresp_q <= rd_dec[3] ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rd_dec[3] ? {24'h00_0000, regs_q[rd_dec[2:0]]} : 32'h0000_0000;
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Hardware set and clear terms
    // ****************************************************************
    // Events land in the flag nibble of their register
    always_comb
    begin
        set_v[IDX_GROUP_CTRL] = {grp_set, 4'h0};
        set_v[IDX_TBPIN] = {ev_timebase_pin, 4'h0};
        set_v[IDX_SERUART] = {1'b0, ev_serial_uart, 4'h0};
        set_v[IDX_PTIMER] = {ev_ptimer, 4'h0};
        set_v[IDX_VOLTSTM] = {ev_volt_stm, 4'h0};
        set_v[IDX_ATIMER] = {1'b0, ev_atimer, 4'h0};
        set_v[IDX_PIN23] = {2'h0, ev_pin23, 4'h0};
        set_v[IDX_GLOBAL] = 8'h00;
    end

    // Implemented bits; unused bits never store anything
    always_comb
    begin
        mask_v[IDX_GROUP_CTRL] = MASK_FULL;
        mask_v[IDX_TBPIN] = MASK_FULL;
        mask_v[IDX_SERUART] = MASK_SERUART;
        mask_v[IDX_PTIMER] = MASK_FULL;
        mask_v[IDX_VOLTSTM] = MASK_FULL;
        mask_v[IDX_ATIMER] = MASK_ATIMER;
        mask_v[IDX_PIN23] = MASK_PIN23;
        mask_v[IDX_GLOBAL] = MASK_GLOBAL;
    end

    // Service clears group pending, pin4/pin5 and global enable; source flags are left alone
    always_comb
    begin
        clr_v = '{default: 8'h00};
        if (svc_ack)
        begin
            clr_v[IDX_GLOBAL][GLOBAL_BIT] = 1'b1;
            if (svc_index <= SVC_GROUP_LAST)
            begin
                clr_v[IDX_GROUP_CTRL][FLAG_LSB + int'(svc_index[1:0])] = 1'b1;
            end
            if (svc_index == SVC_PIN4)
            begin
                clr_v[IDX_TBPIN][PIN4_FLAG_BIT] = 1'b1;
            end
            if (svc_index == SVC_PIN5)
            begin
                clr_v[IDX_TBPIN][PIN5_FLAG_BIT] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Register bank storage
    // ****************************************************************
    generate
        for (genvar r = 0; r < NUM_REGS; r++)
        begin : g_reg
            // Byte lane 0 gates the software write
            assign regs_d[r] = next_value(regs_q[r], wr_go && wr_dec[3] && w_lane_q &&
                                          (wr_dec[2:0] == 3'(r)), w_data_q, mask_v[r], clr_v[r], set_v[r]);

            // All bits clear at reset, then follow the next value
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    regs_q[r] <= REG_RESET;
                end
                else
                begin
                    regs_q[r] <= regs_d[r];
                end
            end
        end

        // Group g fed by bank IDX_PTIMER+g; an enabled flag rising, even by a write, sets it
        for (genvar g = 0; g < NUM_GROUPS; g++)
        begin : g_grp
            assign grp_set[g] = |(regs_d[int'(IDX_PTIMER) + g][FLAG_LSB +: NIB_W] &
                                  ~regs_q[int'(IDX_PTIMER) + g][FLAG_LSB +: NIB_W] &
                                  regs_q[int'(IDX_PTIMER) + g][ENA_LSB +: NIB_W]);
        end
    endgenerate

    // ****************************************************************
    // Request outputs
    // ****************************************************************
    assign global_en = regs_q[IDX_GLOBAL][GLOBAL_BIT];

    // A flag stays recorded but raises nothing while its enable is low
    always_comb
    begin
        irq_active = '0;
        if (global_en)
        begin
            irq_active[3:0] = regs_q[IDX_GROUP_CTRL][FLAG_LSB +: NIB_W] &
                              regs_q[IDX_GROUP_CTRL][ENA_LSB +: NIB_W];
            irq_active[7:4] = regs_q[IDX_TBPIN][FLAG_LSB +: NIB_W] &
                              regs_q[IDX_TBPIN][ENA_LSB +: NIB_W];
            irq_active[11:8] = regs_q[IDX_SERUART][FLAG_LSB +: NIB_W] &
                               regs_q[IDX_SERUART][ENA_LSB +: NIB_W];
        end
    end

    assign irq_request = |irq_active;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Write handshake pair followed by an answer
    sequence aw_taken_s;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence w_taken_s;
        s_axi_wvalid && s_axi_wready;
    endsequence
    group_set_a: assert property ((|(regs_q[IDX_PTIMER][FLAG_LSB +: NIB_W]
                                    & ~$past(regs_q[IDX_PTIMER][FLAG_LSB +: NIB_W])
                                    & $past(regs_q[IDX_PTIMER][ENA_LSB +: NIB_W])))
                                  |-> regs_q[IDX_GROUP_CTRL][FLAG_LSB])
        else $error("group 0 pending not set by its source");
    pin_clear_a: assert property ((svc_ack && svc_index == SVC_PIN4 && !ev_timebase_pin[2])
                                  |=> !regs_q[IDX_TBPIN][PIN4_FLAG_BIT])
        else $error("pin4 flag not cleared on service");
    source_hold_a: assert property ((svc_ack && regs_q[IDX_PTIMER][FLAG_LSB] && !wr_go)
                                    |=> regs_q[IDX_PTIMER][FLAG_LSB])
        else $error("group source flag cleared by service");
    request_gate_a: assert property (irq_active[4] |-> (global_en && regs_q[IDX_TBPIN][ENA_LSB]
                                     && regs_q[IDX_TBPIN][FLAG_LSB]))
        else $error("request raised without enable");
    global_block_a: assert property ((svc_ack && !wr_go) |=> (!global_en && irq_active == '0))
        else $error("requests not blocked after service");
    set_wins_a: assert property ((ev_ptimer[0] && wr_go && wr_dec == {1'b1, IDX_PTIMER})
                                 |=> regs_q[IDX_PTIMER][FLAG_LSB])
        else $error("event lost against clearing write");
    unused_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h00_0000))
        else $error("bits above byte read nonzero");
    pin23_zero_a: assert property (regs_q[IDX_PIN23][7:6] == 2'h0 && regs_q[IDX_PIN23][3:2] == 2'h0
                                   && regs_q[IDX_ATIMER][7] == 1'b0 && regs_q[IDX_ATIMER][3] == 1'b0)
        else $error("unimplemented bit stored");
    reset_zero_a: assert property ($rose(aresetn) |-> (regs_q[IDX_TBPIN] == REG_RESET
                                   && regs_q[IDX_PTIMER] == REG_RESET))
        else $error("register not zero after reset");
    write_answer_a: assert property ((aw_taken_s and w_taken_s) |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");

endmodule

`default_nettype wire

/* File: sim/ifeb_event_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Peripheral event sources: one-cycle pulses on the system clock
// ****************************************************************
module ifeb_event_src
(
    input wire logic fire,
    input wire logic [2:0] fire_reg,
    input wire logic [1:0] fire_bit,
    output logic [3:0] ev_timebase_pin,
    output logic [2:0] ev_serial_uart,
    output logic [3:0] ev_ptimer,
    output logic [3:0] ev_volt_stm,
    output logic [2:0] ev_atimer,
    output logic [1:0] ev_pin23
);
    logic [3:0] hot; // One-hot pulse for the chosen source
    // Combinational, so a pulse lasts exactly as long as fire is held
    always_comb
    begin
        hot = fire ? (4'h1 << fire_bit) : 4'h0;
        ev_timebase_pin = (fire_reg == 3'h1) ? hot : 4'h0;
        ev_serial_uart = (fire_reg == 3'h2) ? hot[2:0] : 3'h0;
        ev_ptimer = (fire_reg == 3'h3) ? hot : 4'h0;
        ev_volt_stm = (fire_reg == 3'h4) ? hot : 4'h0;
        ev_atimer = (fire_reg == 3'h5) ? hot[2:0] : 3'h0;
        ev_pin23 = (fire_reg == 3'h6) ? hot[1:0] : 2'h0;
    end
endmodule
`default_nettype wire

/* File: sim/interrupt_flag_enable_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module interrupt_flag_enable_bank_bench;
    import ifeb_pkg::*;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0, svc_index = 4'h0, ev_timebase_pin, ev_ptimer, ev_volt_stm;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, svc_ack = 1'b0, fire = 1'b0;
    logic [2:0] fire_reg = 3'h0, ev_serial_uart, ev_atimer;
    logic [1:0] fire_bit = 2'h0, ev_pin23, s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_request;
    logic [NUM_REQ-1:0] irq_active;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [3:0] lane = 4'h1; // Write strobes for the next write; lane 0 gates the register
    logic [7:0] m [8]; // Reference copy of the register bank
    always #50 aclk = ~aclk;
    ifeb_flag_bank DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ev_timebase_pin, .ev_serial_uart, .ev_ptimer, .ev_volt_stm, .ev_atimer,
        .ev_pin23, .svc_ack, .svc_index, .irq_active, .irq_request);
    ifeb_event_src SRC (.fire, .fire_reg, .fire_bit, .ev_timebase_pin, .ev_serial_uart, .ev_ptimer,
        .ev_volt_stm, .ev_atimer, .ev_pin23);
    // ****************************************************************
    // Reference model
    // ****************************************************************
    function automatic logic [7:0] msk(int i);
        case (i)
            2: return MASK_SERUART;
            5: return MASK_ATIMER;
            6: return MASK_PIN23;
            7: return MASK_GLOBAL;
            default: return MASK_FULL;
        endcase
    endfunction
    // Request vector: pending and enable, all gated by the global enable
    function automatic logic [11:0] exp_irq();
        logic [11:0] e;
        e = 12'h0;
        for (int g = 0; g < 4; g++)
        begin
            e[g] = m[0][4+g] & m[0][g];
            e[4+g] = m[1][4+g] & m[1][g];
            if (g < 3)
                e[8+g] = m[2][4+g] & m[2][g];
        end
        return m[7][0] ? e : 12'h0;
    endfunction
    // ****************************************************************
    // Bus and event tasks; each starts one edge after the last one ends
    // ****************************************************************
    task automatic wr(input int i, input logic [7:0] d, input bit hit, output logic [1:0] rsp);
        bit ad;
        bit dd;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        s_axi_awaddr <= 8'(i * 4);
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= lane;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                dd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Event lands on the very edge that applies the write
        if (hit)
        begin
            fire <= 1'b1;
            @(posedge aclk);
            fire <= 1'b0;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input int i, output logic [31:0] d, output logic [1:0] rsp);
        @(posedge aclk);
        s_axi_araddr <= 8'(i * 4);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic check_all();
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        `CHK("irq_active", exp_irq(), irq_active)
        `CHK("irq_request", |exp_irq(), irq_request)
        for (int i = 0; i < 8; i++)
        begin
            rd(i, d, r);
            `CHK("rdata", {24'h0, m[i]}, d)
            `CHK("rresp", RESP_OKAY, r)
        end
    endtask
    // Source event; group pending follows an enabled flag rising
    task automatic fire_ev(input int i, input int b);
        @(posedge aclk);
        fire_reg <= 3'(i);
        fire_bit <= 2'(b);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (2) @(posedge aclk);
        if (i >= 3 && !m[i][4+b] && m[i][b])
            m[0][1+i] = 1'b1;
        m[i][4+b] = 1'b1;
    endtask
    task automatic svc(input int k);
        @(posedge aclk);
        svc_ack <= 1'b1;
        svc_index <= 4'(k);
        @(posedge aclk);
        svc_ack <= 1'b0;
        m[7] = 8'h00;
        if (k < 4)
            m[0][4+k] = 1'b0;
        if (k == 6 || k == 7)
            m[1][k] = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard; the whole run needs well under this many cycles
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        int i;
        void'($urandom(2437));
        foreach (m[k])
            m[k] = 8'h00;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        check_all();
        rd(8, d, r);
        `CHK("rresp", RESP_SLVERR, r)
        `CHK("rdata", 32'h0, d)
        wr(9, 8'hff, 0, r);
        `CHK("bresp", RESP_SLVERR, r)
        $display("test reset_and_map done");
        // Random lanes; a write with lane 0 off changes nothing but still answers OKAY
        repeat (4)
        begin
            for (i = 7; i >= 0; i--)
            begin
                d = $urandom;
                lane = d[11:8];
                wr(i, d[7:0], 0, r);
                // A written source flag rising under its enable sets the group pending
                if (i >= 3 && lane[0] && |(d[7:4] & ~m[i][7:4] & m[i][3:0]))
                    m[0][1+i] = 1'b1;
                if (lane[0])
                    m[i] = d[7:0] & msk(i);
                `CHK("bresp", RESP_OKAY, r)
            end
            check_all();
        end
        lane = 4'h1;
        $display("test random_rw done");
        for (i = 0; i < 8; i++)
        begin
            wr(i, 8'h00, 0, r);
            m[i] = 8'h00;
        end
        // Software only clears flags here, so only events set them
        repeat (60)
        begin
            i = $urandom_range(6, 1);
            case ($urandom % 4)
                0: fire_ev(i, $urandom % ((i == 6) ? 2 : (i == 2 || i == 5) ? 3 : 4));
                1: svc($urandom % 12);
                2:
                begin
                    i = $urandom % 7;
                    d = $urandom;
                    d[7:4] = d[7:4] & m[i][7:4];
                    wr(i, d[7:0], 0, r);
                    m[i] = d[7:0] & msk(i);
                end
                default:
                begin
                    wr(7, 8'h01, 0, r);
                    m[7] = 8'h01;
                end
            endcase
            check_all();
        end
        $display("test events_service done");
        wr(3, 8'h01, 0, r);
        m[3] = 8'h01;
        fire_ev(3, 0);
        wr(3, 8'h01, 1, r);
        check_all();
        $display("test set_beats_clear done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
